// ===== design/diskette_pkg.sv
// Purpose: Shared constants and types of the diskette command interface.
// Assumes: Immediate data bit 16 sits at index 15, so channel bit n is index 31-n.
// Notes: Control word bit n sits at index 15-n of the 16-bit word.
package diskette_pkg;
  localparam logic [7:0] CMD_PREPARE = 8'h60;
  localparam logic [7:0] CMD_READ_ID = 8'h20;
  localparam logic [7:0] CMD_DEV_RESET = 8'h6f;
  localparam logic [7:0] CMD_HALT = 8'hf0;
  localparam logic [7:0] CMD_START = 8'h70;
  // Identification word; the value is arbitrary.
  localparam logic [15:0] DEVICE_ID = 16'h0a5c;
  // Condition codes as {even, carry, overflow}.
  localparam logic [2:0] CC_ACCEPTED = 3'h7;
  localparam logic [2:0] CC_BUSY = 3'h1;
  localparam logic [2:0] CC_REJECT = 3'h3;
  localparam logic [2:0] INT_CC_EXCEPTION = 3'h2;
  localparam logic [2:0] INT_CC_DEVICE_END = 3'h3;
  localparam int IMM_LEVEL_MSB = 4;
  localparam int IMM_LEVEL_LSB = 1;
  localparam int IMM_ALLOW = 0;
  localparam int CW_CHAIN = 15;
  localparam int CW_INPUT = 13;
  localparam int CW_SUPPRESS = 11;
  localparam int MOD_SPIRAL = 7;
  localparam int MOD_NO_SEEK = 3;
  localparam int DCB_WORDS = 8;
  localparam logic [2:0] W_CTRL = 3'h0;
  localparam logic [2:0] W_RSB = 3'h4;
  localparam logic [2:0] W_CHAIN = 3'h5;
  localparam logic [2:0] W_COUNT = 3'h6;
  localparam logic [2:0] W_DATA = 3'h7;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam int RSB_END_CHAIN = 15;
  localparam int RSB_NO_EXCEPTION = 0;
  localparam int ERR_SPEC = 2;
  localparam int ERR_STORAGE = 1;
  localparam int ERR_DRIVE = 0;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_RECAL = 4'h1, OP_FORMAT = 4'h2, OP_FORMAT_DEFECT = 4'h3,
    OP_DENSITY = 4'h4, OP_FORMAT_VERIFY = 4'h5, OP_READ = 4'h6, OP_READ_VER_CHECK = 4'h7,
    OP_READ_VER_COMPARE = 4'h8, OP_READ_SECTOR_ID = 4'h9, OP_READ_DIAG = 4'ha,
    OP_WRITE_DATA = 4'hb, OP_WRITE_CONTROL = 4'hc, OP_WRITE_VERIFY = 4'hd
  } op_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_FETCH = 3'b001, ST_CHECK = 3'b010, ST_DRIVE_IN = 3'b011,
    ST_STORE = 3'b100, ST_NEXT = 3'b101, ST_RSB = 3'b110, ST_END = 3'b111
  } state_type;
endpackage

// ===== design/control_decode_if.sv
// Purpose: Carries control word 0 to its decoder and the decoded fields back.
// Assumes: Purely combinational between the two ends.
// Notes: None.
`timescale 1ns/1ps
interface control_decode_if;
  logic [15:0] ctrl;
  diskette_pkg::op_type op;
  logic valid;
  logic spiral;
  logic auto_seek;
  logic chain;
  logic input_dir;
  logic suppress;
  modport decoder(input ctrl, output op, valid, spiral, auto_seek, chain, input_dir, suppress);
  modport user(output ctrl, input op, valid, spiral, auto_seek, chain, input_dir, suppress);
endinterface

// ===== design/control_word_decoder.sv
// Purpose: Decodes the control word of a device control block.
// Assumes: Modifier field is the low byte, control flags the high byte.
// Notes: A modifier outside the table, or one with the wrong direction, is invalid.
`timescale 1ns/1ps
module control_word_decoder (
  control_decode_if.decoder dec
);
  logic need_input;

  always_comb
  begin
    dec.op = diskette_pkg::OP_NONE;
    need_input = 1'b0;
    casez (dec.ctrl[7:0]) // [R14] [R15] [R16]
      8'b0000_0010: dec.op = diskette_pkg::OP_RECAL;
      8'b0000_?100: dec.op = diskette_pkg::OP_FORMAT;
      8'b0000_?101: dec.op = diskette_pkg::OP_FORMAT_DEFECT;
      8'b0000_0111: dec.op = diskette_pkg::OP_DENSITY;
      8'b0000_?110: dec.op = diskette_pkg::OP_FORMAT_VERIFY;
      8'b?001_?000:
      begin
        dec.op = diskette_pkg::OP_READ;
        need_input = 1'b1;
      end
      8'b?001_?001: dec.op = diskette_pkg::OP_READ_VER_CHECK;
      8'b?001_?010: dec.op = diskette_pkg::OP_READ_VER_COMPARE;
      8'b0001_?100:
      begin
        dec.op = diskette_pkg::OP_READ_SECTOR_ID;
        need_input = 1'b1;
      end
      8'b0001_?110:
      begin
        dec.op = diskette_pkg::OP_READ_DIAG;
        need_input = 1'b1;
      end
      8'b?010_?000: dec.op = diskette_pkg::OP_WRITE_DATA;
      8'b?010_?001: dec.op = diskette_pkg::OP_WRITE_CONTROL;
      8'b?010_?010: dec.op = diskette_pkg::OP_WRITE_VERIFY;
      default: dec.op = diskette_pkg::OP_NONE;
    endcase
  end

  assign dec.input_dir = dec.ctrl[diskette_pkg::CW_INPUT]; // [R13]
  assign dec.valid = (dec.op != diskette_pkg::OP_NONE) && (dec.input_dir == need_input); // [R13]
  assign dec.spiral = dec.ctrl[diskette_pkg::MOD_SPIRAL]; // [R17]
  assign dec.auto_seek = ~dec.ctrl[diskette_pkg::MOD_NO_SEEK]; // [R18]
  assign dec.chain = dec.ctrl[diskette_pkg::CW_CHAIN];
  assign dec.suppress = dec.ctrl[diskette_pkg::CW_SUPPRESS];
endmodule

// ===== design/diskette_io_command_interface.sv
// Purpose: Channel-side command interpreter of the internal diskette attachment.
// Assumes: Channel, storage and drive logic share sys_clk; one command strobe per cycle.
// Notes: Storage addresses are byte addresses; words sit at even addresses.
// Operation
// [R1] Prepare latches level from bits 27-30 and allow bit from bit 31.
// [R2] Interrupt requests appear on the latched level only while allow bit is one.
// [R3] Read ID returns the fixed identification word in the immediate data.
// [R4] Device reset clears pending interrupt and busy, keeps level and residual address.
// [R5] Halt stops all activity, resets, clears interrupt and busy, keeps level.
// [R6] Each immediate command gives one transfer and one condition code.
// [R7] Start returns a condition code, then fetches block and data by cycle steal.
// [R8] After word 6 byte count moves, interrupt with code and identification word.
// [R9] Chaining applies only to start; an unchained end raises an interrupt.
// [R10] Chain bit set: skip interrupt, fetch next block from word 5 address.
// [R11] Any error stops the chain and raises an interrupt at once.
// [R12] Issuer writes zero into control word bits 1 and 3.
// [R13] Control bit 2 one moves device to storage; zero otherwise or no data.
// [R14] Decode recalibrate, format, defective format, density and format verify modifiers.
// [R15] Decode read, read verify check, read compare, sector ID and diagnostic reads.
// [R16] Decode write data mark, write control mark and write with read verify.
// [R17] Modifier bit 8 one enables spiral operation.
// [R18] Modifier bit 12 zero asks automatic seek, one suppresses it.
// [R19] Issuer should request automatic seek with every spiral operation.
// [R20] Suppress bit stores status at the residual block address of word 4.
// [R21] With suppress, every chained block stores a residual block when error free.
// [R22] Issuer keeps the immediate control block on a fullword boundary.
// [R23] An odd residual block address in word 4 is a specification check; the code flags it only when the suppress bit is set.
`timescale 1ns/1ps
module diskette_io_command_interface (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_data,
  output logic cc_valid,
  output logic [2:0] cc,
  output logic [15:0] cc_data,
  input wire logic irq_ack,
  output logic irq_req,
  output logic [3:0] irq_level,
  output logic int_valid,
  output logic [2:0] int_cc,
  output logic [15:0] int_id,
  output logic busy,
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic mem_error,
  input wire logic [15:0] mem_rdata,
  output logic op_start,
  output logic [3:0] op_kind,
  output logic op_spiral,
  output logic op_auto_seek,
  input wire logic disk_in_valid,
  input wire logic [15:0] disk_in_data,
  output logic disk_in_ready,
  output logic disk_out_valid,
  output logic [15:0] disk_out_data,
  input wire logic disk_error
);
  diskette_pkg::state_type state;
  logic [15:0] dcb [diskette_pkg::DCB_WORDS];
  logic [2:0] fetch_index;
  logic [15:0] words_left;
  logic [15:0] data_addr;
  logic [2:0] err_flags;
  logic rsb_second;
  logic allow;
  logic irq_pend;
  logic end_pulse;
  logic kill;
  logic start_ok;
  logic chain_go;
  logic [15:0] next_words;
  control_decode_if dec_if ();

  control_word_decoder decoder_inst (
    .dec(dec_if.decoder)
  );

  assign dec_if.ctrl = dcb[diskette_pkg::W_CTRL];
  assign kill = cmd_valid && (cmd_code == diskette_pkg::CMD_DEV_RESET
    || cmd_code == diskette_pkg::CMD_HALT); // [R4] [R5]
  assign start_ok = cmd_valid && cmd_code == diskette_pkg::CMD_START
    && state == diskette_pkg::ST_IDLE && !irq_pend;
  // Only a start operation reaches the chaining decision.
  assign chain_go = dec_if.chain && err_flags == 3'h0; // [R9] [R10] [R11]
  // Byte count rounded up to whole words.
  assign next_words = {1'b0, dcb[diskette_pkg::W_COUNT][15:1]}
    + {15'h0000, dcb[diskette_pkg::W_COUNT][0]}; // [R8]

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_level <= 4'h0;
      allow <= 1'b0;
    end
    else if (cmd_valid && cmd_code == diskette_pkg::CMD_PREPARE)
    begin
      irq_level <= cmd_data[diskette_pkg::IMM_LEVEL_MSB:diskette_pkg::IMM_LEVEL_LSB]; // [R1]
      allow <= cmd_data[diskette_pkg::IMM_ALLOW]; // [R1]
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cc_valid <= 1'b0;
      cc <= 3'h0;
      cc_data <= 16'h0000;
    end
    else
    begin
      cc_valid <= cmd_valid; // [R6]
      if (cmd_valid)
      begin
        cc <= diskette_pkg::CC_ACCEPTED;
        cc_data <= 16'h0000;
        case (cmd_code)
          diskette_pkg::CMD_PREPARE: cc <= diskette_pkg::CC_ACCEPTED;
          diskette_pkg::CMD_READ_ID: cc_data <= diskette_pkg::DEVICE_ID; // [R3]
          diskette_pkg::CMD_DEV_RESET: cc <= diskette_pkg::CC_ACCEPTED;
          diskette_pkg::CMD_HALT: cc <= diskette_pkg::CC_ACCEPTED;
          diskette_pkg::CMD_START: cc <= start_ok ? diskette_pkg::CC_ACCEPTED
            : diskette_pkg::CC_BUSY; // [R7]
          default: cc <= diskette_pkg::CC_REJECT;
        endcase
      end
    end
  end

  // A fresh end of operation beats an acknowledge in the same cycle.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_pend <= 1'b0;
      irq_req <= 1'b0;
      int_valid <= 1'b0;
      int_cc <= 3'h0;
      int_id <= 16'h0000;
    end
    else
    begin
      int_valid <= 1'b0;
      if (kill || (cmd_valid && cmd_code == diskette_pkg::CMD_PREPARE
        && !cmd_data[diskette_pkg::IMM_ALLOW]))
      begin
        irq_pend <= 1'b0; // [R2] [R4] [R5]
        irq_req <= 1'b0;
      end
      else if (end_pulse && allow)
      begin
        irq_pend <= 1'b1; // [R8] [R9]
        irq_req <= 1'b1; // [R2]
        int_cc <= (err_flags != 3'h0) ? diskette_pkg::INT_CC_EXCEPTION
          : diskette_pkg::INT_CC_DEVICE_END;
        int_id <= {13'h0000, err_flags};
      end
      else if (irq_ack && irq_pend)
      begin
        irq_pend <= 1'b0;
        irq_req <= 1'b0;
        int_valid <= 1'b1; // [R8]
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= diskette_pkg::ST_IDLE;
      busy <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 16'h0000;
      fetch_index <= 3'h0;
      words_left <= 16'h0000;
      data_addr <= 16'h0000;
      err_flags <= 3'h0;
      rsb_second <= 1'b0;
      end_pulse <= 1'b0;
      op_start <= 1'b0;
      op_kind <= 4'h0;
      op_spiral <= 1'b0;
      op_auto_seek <= 1'b0;
      disk_in_ready <= 1'b0;
      disk_out_valid <= 1'b0;
      disk_out_data <= 16'h0000;
      for (int i = 0; i < diskette_pkg::DCB_WORDS; i++)
      begin
        dcb[i] <= 16'h0000;
      end
    end
    else if (kill)
    begin
      state <= diskette_pkg::ST_IDLE; // [R4] [R5]
      busy <= 1'b0;
      mem_req <= 1'b0;
      end_pulse <= 1'b0;
      op_start <= 1'b0;
      disk_in_ready <= 1'b0;
      disk_out_valid <= 1'b0;
    end
    else
    begin
      end_pulse <= 1'b0;
      op_start <= 1'b0;
      disk_out_valid <= 1'b0;
      case (state)
        diskette_pkg::ST_IDLE:
        begin
          if (start_ok)
          begin
            state <= diskette_pkg::ST_FETCH; // [R7]
            busy <= 1'b1;
            err_flags <= 3'h0;
            fetch_index <= 3'h0;
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= cmd_data;
          end
        end
        diskette_pkg::ST_FETCH:
        begin
          if (mem_ack)
          begin
            mem_req <= 1'b0;
            dcb[fetch_index] <= mem_rdata; // [R7]
            if (mem_error)
            begin
              err_flags[diskette_pkg::ERR_STORAGE] <= 1'b1;
              state <= diskette_pkg::ST_END;
            end
            else if (fetch_index == diskette_pkg::W_DATA)
            begin
              state <= diskette_pkg::ST_CHECK;
            end
            else
            begin
              fetch_index <= fetch_index + 3'h1;
              mem_req <= 1'b1;
              mem_addr <= mem_addr + diskette_pkg::WORD_STEP;
            end
          end
        end
        diskette_pkg::ST_CHECK:
        begin
          words_left <= next_words; // [R8]
          data_addr <= dcb[diskette_pkg::W_DATA];
          if (!dec_if.valid || (dec_if.suppress && dcb[diskette_pkg::W_RSB][0]))
          begin
            err_flags[diskette_pkg::ERR_SPEC] <= 1'b1; // [R13] [R23]
            state <= diskette_pkg::ST_END;
          end
          else
          begin
            op_start <= 1'b1;
            op_kind <= dec_if.op; // [R14] [R15] [R16]
            op_spiral <= dec_if.spiral; // [R17]
            op_auto_seek <= dec_if.auto_seek; // [R18]
            state <= diskette_pkg::ST_NEXT;
          end
        end
        diskette_pkg::ST_NEXT:
        begin
          if (words_left == 16'h0000)
          begin
            rsb_second <= 1'b0;
            mem_we <= 1'b1;
            mem_addr <= dcb[diskette_pkg::W_RSB];
            mem_wdata <= 16'h0000;
            mem_req <= dec_if.suppress; // [R20]
            state <= dec_if.suppress ? diskette_pkg::ST_RSB : diskette_pkg::ST_END;
          end
          else if (dec_if.input_dir)
          begin
            disk_in_ready <= 1'b1; // [R13]
            state <= diskette_pkg::ST_DRIVE_IN;
          end
          else
          begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= data_addr;
            state <= diskette_pkg::ST_STORE;
          end
        end
        diskette_pkg::ST_DRIVE_IN:
        begin
          if (disk_in_valid)
          begin
            disk_in_ready <= 1'b0;
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= data_addr;
            mem_wdata <= disk_in_data;
            state <= diskette_pkg::ST_STORE;
          end
        end
        diskette_pkg::ST_STORE:
        begin
          if (mem_ack)
          begin
            mem_req <= 1'b0;
            if (mem_error)
            begin
              err_flags[diskette_pkg::ERR_STORAGE] <= 1'b1;
              state <= diskette_pkg::ST_END;
            end
            else
            begin
              disk_out_valid <= !mem_we;
              disk_out_data <= mem_rdata;
              words_left <= words_left - 16'h0001;
              data_addr <= data_addr + diskette_pkg::WORD_STEP;
              state <= diskette_pkg::ST_NEXT;
            end
          end
        end
        diskette_pkg::ST_RSB:
        begin
          // Word 0 is the residual count, always zero; word 1 holds the flags.
          if (mem_ack)
          begin
            mem_req <= !rsb_second;
            rsb_second <= 1'b1;
            mem_addr <= mem_addr + diskette_pkg::WORD_STEP;
            mem_wdata <= 16'h0000;
            mem_wdata[diskette_pkg::RSB_END_CHAIN] <= !dec_if.chain;
            mem_wdata[diskette_pkg::RSB_NO_EXCEPTION] <= 1'b1;
            if (rsb_second || mem_error)
            begin
              mem_req <= 1'b0;
              err_flags[diskette_pkg::ERR_STORAGE] <= mem_error;
              state <= diskette_pkg::ST_END; // [R21]
            end
          end
        end
        diskette_pkg::ST_END:
        begin
          if (chain_go)
          begin
            state <= diskette_pkg::ST_FETCH; // [R10]
            fetch_index <= 3'h0;
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= dcb[diskette_pkg::W_CHAIN]; // [R10]
          end
          else
          begin
            state <= diskette_pkg::ST_IDLE;
            busy <= 1'b0;
            end_pulse <= 1'b1; // [R9] [R11]
          end
        end
        default: state <= diskette_pkg::ST_IDLE;
      endcase
      if (disk_error && state != diskette_pkg::ST_IDLE && state != diskette_pkg::ST_END)
      begin
        err_flags[diskette_pkg::ERR_DRIVE] <= 1'b1; // [R11]
        mem_req <= 1'b0;
        disk_in_ready <= 1'b0;
        state <= diskette_pkg::ST_END;
      end
    end
  end

  AST_PREPARE_LATCH: assert property (@(posedge sys_clk) disable iff (rst) // [R1]
    cmd_valid && cmd_code == diskette_pkg::CMD_PREPARE
    |=> irq_level == $past(cmd_data[4:1]) && allow == $past(cmd_data[0]))
    else $error("Prepare did not latch level and allow bit.");
  AST_NO_REQ_WHEN_BLOCKED: assert property (@(posedge sys_clk) disable iff (rst) // [R2]
    !allow |-> !irq_req)
    else $error("Interrupt request raised while not allowed.");
  AST_READ_ID_WORD: assert property (@(posedge sys_clk) disable iff (rst) // [R3]
    cmd_valid && cmd_code == diskette_pkg::CMD_READ_ID
    |=> cc_valid && cc_data == diskette_pkg::DEVICE_ID)
    else $error("Identification word not returned.");
  AST_RESET_CLEARS: assert property (@(posedge sys_clk) disable iff (rst) // [R4]
    kill |=> !irq_req && !busy && state == diskette_pkg::ST_IDLE && $stable(irq_level))
    else $error("Reset or halt left activity or changed the level.");
  AST_HALT_QUIET: assert property (@(posedge sys_clk) disable iff (rst) // [R5]
    cmd_valid && cmd_code == diskette_pkg::CMD_HALT |=> !mem_req && !disk_in_ready)
    else $error("Halt left storage or drive activity running.");
  AST_ONE_CODE: assert property (@(posedge sys_clk) disable iff (rst) // [R6]
    cc_valid |-> $past(cmd_valid) ##1 (cc_valid == $past(cmd_valid)))
    else $error("Condition code not paired with a single command.");
  AST_START_FETCH: assert property (@(posedge sys_clk) disable iff (rst) // [R7]
    start_ok |=> cc == diskette_pkg::CC_ACCEPTED && mem_req && !mem_we
    && mem_addr == $past(cmd_data))
    else $error("Start did not begin the block fetch.");
  AST_END_INTERRUPT: assert property (@(posedge sys_clk) disable iff (rst) // [R8]
    end_pulse && allow && !kill |=> irq_req && irq_pend)
    else $error("Operation end raised no interrupt.");
  AST_CHAIN_ADDRESS: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
    state == diskette_pkg::ST_END && chain_go && !kill
    |=> state == diskette_pkg::ST_FETCH && mem_addr == $past(dcb[5]) && !end_pulse)
    else $error("Chain did not fetch from the word 5 address.");
  AST_ERROR_STOPS_CHAIN: assert property (@(posedge sys_clk) disable iff (rst) // [R11]
    state == diskette_pkg::ST_END && err_flags != 3'h0 && !kill
    |=> state == diskette_pkg::ST_IDLE && end_pulse)
    else $error("Error did not end the chain.");
  AST_ODD_RSB: assert property (@(posedge sys_clk) disable iff (rst) // [R23]
    state == diskette_pkg::ST_CHECK && dec_if.suppress && dcb[4][0] && !kill && !disk_error
    |=> err_flags[diskette_pkg::ERR_SPEC] && !op_start)
    else $error("Odd residual address not flagged.");
endmodule

// ===== tb/storage_model.sv
// Purpose: Processor storage that answers cycle-steal requests.
// Assumes: Word array indexed by byte address bits 8:1.
// Notes: The answer delay is set by the bench to act prompt or slow.
`timescale 1ns/1ps
module storage_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] delay,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_ack,
  output logic mem_error,
  output logic [15:0] mem_rdata
);
  logic [15:0] mem [256];
  logic [3:0] cnt;
  logic [15:0] last;
  assign mem_error = 1'b0;
  // Outside an answer the bus carries no stale word, so a late sample shows up.
  assign mem_rdata = mem_ack ? last : ~last;
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
      last <= 16'h0000;
    end
    else
    begin
      mem_ack <= 1'b0;
      if (!mem_req || mem_ack)
        cnt <= 4'h0;
      else if (cnt >= delay)
      begin
        mem_ack <= 1'b1;
        last <= mem[mem_addr[8:1]];
        if (mem_we)
          mem[mem_addr[8:1]] <= mem_wdata;
      end
      else
        cnt <= cnt + 4'h1;
    end
  end
endmodule

// ===== tb/tb_diskette_io_command_interface.sv
// Purpose: Self-checking bench of the diskette command interpreter.
// Assumes: Storage model answers cycle steals; the drive never reports errors.
// Notes: Block addresses stay below 16'h0200 to fit the storage model.
`timescale 1ns/1ps
module tb_diskette_io_command_interface;
  logic sys_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, irq_ack = 1'b0;
  logic disk_in_valid = 1'b0, disk_error = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic [15:0] cmd_data = 16'h0000, disk_in_data = 16'hc3a5;
  logic [3:0] delay = 4'h0;
  logic cc_valid, irq_req, int_valid, busy, mem_req, mem_we, mem_ack, mem_error;
  logic op_start, op_spiral, op_auto_seek, disk_in_ready, disk_out_valid;
  logic [2:0] cc, int_cc;
  logic [3:0] irq_level, op_kind, seen_op;
  logic [15:0] cc_data, int_id, mem_addr, mem_wdata, mem_rdata, disk_out_data, seen_out;
  logic [1:0] seen_opt;
  logic [15:0] tab [13] = '{16'h0002, 16'h000c, 16'h0005, 16'h0007, 16'h0006, 16'h2090,
    16'h0011, 16'h0012, 16'h201c, 16'h2016, 16'h0020, 16'h00a1, 16'h0022};
  int mismatches = 0, checks = 0, cycles = 0, starts = 0, outs = 0, s0, n;
  diskette_io_command_interface diskette_io_command_interface_inst (.sys_clk, .rst,
    .cmd_valid, .cmd_code, .cmd_data, .cc_valid, .cc, .cc_data, .irq_ack, .irq_req,
    .irq_level, .int_valid, .int_cc, .int_id, .busy, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_ack, .mem_error, .mem_rdata, .op_start, .op_kind, .op_spiral,
    .op_auto_seek, .disk_in_valid, .disk_in_data, .disk_in_ready, .disk_out_valid,
    .disk_out_data, .disk_error);
  storage_model storage_model_inst (.sys_clk, .rst, .delay, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_ack, .mem_error, .mem_rdata);
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    if (op_start)
    begin
      starts <= starts + 1;
      seen_op <= op_kind;
      seen_opt <= {op_spiral, op_auto_seek};
    end
    if (disk_out_valid)
    begin
      outs <= outs + 1;
      seen_out <= disk_out_data;
    end
  end
  always @(posedge sys_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 30000)
    begin
      mismatches = mismatches + 1;
      finish_test;
    end
  end
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    checks = checks + 1;
    if (s !== e)
    begin
      mismatches = mismatches + 1;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task finish_test;
    if (mismatches == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task cmd(input logic [7:0] c, input logic [15:0] d, input logic [2:0] e);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_data <= d;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    #1;
    chk("cc_valid", {15'h0, cc_valid}, 16'h0001);
    chk("cc", {13'h0, cc}, {13'h0, e});
  endtask
  // Word addresses are even, as the issuer must keep them.
  task dcb(input logic [15:0] a, c, r, nx, k, d);
    for (int i = 0; i < 8; i++)
      storage_model_inst.mem[a[8:1] + i] = 16'h0000;
    storage_model_inst.mem[a[8:1]] = c;
    storage_model_inst.mem[a[8:1] + 4] = r;
    storage_model_inst.mem[a[8:1] + 5] = nx;
    storage_model_inst.mem[a[8:1] + 6] = k;
    storage_model_inst.mem[a[8:1] + 7] = d;
  endtask
  task op_end(input logic irq, input logic [2:0] c, input logic [15:0] id);
    n = 0;
    while (busy !== 1'b0 && n < 2000)
    begin
      @(posedge sys_clk);
      n = n + 1;
    end
    repeat (3) @(posedge sys_clk);
    #1;
    chk("irq_req", {15'h0, irq_req}, {15'h0, irq});
    if (irq)
    begin
      chk("irq_level", {12'h0, irq_level}, 16'h0005);
      @(posedge sys_clk);
      irq_ack <= 1'b1;
      @(posedge sys_clk);
      irq_ack <= 1'b0;
      #1;
      chk("int_valid", {15'h0, int_valid}, 16'h0001);
      chk("int_cc", {13'h0, int_cc}, {13'h0, c});
      chk("int_id", int_id, id);
    end
  endtask
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk("idle", {12'h0, busy, irq_req, cc_valid, mem_req}, 16'h0000);
    cmd(diskette_pkg::CMD_READ_ID, 16'h0000, diskette_pkg::CC_ACCEPTED);
    chk("cc_data", cc_data, diskette_pkg::DEVICE_ID);
    cmd(8'h55, 16'h0000, diskette_pkg::CC_REJECT);
    cmd(diskette_pkg::CMD_PREPARE, 16'h000b, diskette_pkg::CC_ACCEPTED);
    delay <= 4'h3;
    dcb(16'h0040, 16'h0020, 16'h0000, 16'h0000, 16'h0004, 16'h00c0);
    storage_model_inst.mem[8'h60] = 16'h1234;
    storage_model_inst.mem[8'h61] = 16'h5678;
    cmd(diskette_pkg::CMD_START, 16'h0040, diskette_pkg::CC_ACCEPTED);
    cmd(diskette_pkg::CMD_START, 16'h0040, diskette_pkg::CC_BUSY);
    op_end(1'b1, diskette_pkg::INT_CC_DEVICE_END, 16'h0000);
    chk("words out", 16'(outs), 16'h0002);
    chk("last out", seen_out, 16'h5678);
    delay <= 4'h0;
    disk_in_valid <= 1'b1;
    dcb(16'h0040, 16'h2010, 16'h0000, 16'h0000, 16'h0002, 16'h00d0);
    cmd(diskette_pkg::CMD_START, 16'h0040, diskette_pkg::CC_ACCEPTED);
    op_end(1'b1, diskette_pkg::INT_CC_DEVICE_END, 16'h0000);
    chk("stored in", storage_model_inst.mem[8'h68], 16'hc3a5);
    disk_in_valid <= 1'b0;
    for (int i = 0; i < 13; i++)
    begin
      dcb(16'h0040, tab[i], 16'h0000, 16'h0000, 16'h0000, 16'h0000);
      cmd(diskette_pkg::CMD_START, 16'h0040, diskette_pkg::CC_ACCEPTED);
      op_end(1'b1, diskette_pkg::INT_CC_DEVICE_END, 16'h0000);
      chk("op_kind", {12'h0, seen_op}, 16'(i + 1));
      chk("options", {14'h0, seen_opt}, {14'h0, tab[i][7], ~tab[i][3]});
    end
    // A read modifier with the output direction is refused as a spec check.
    dcb(16'h0040, 16'h0010, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    cmd(diskette_pkg::CMD_START, 16'h0040, diskette_pkg::CC_ACCEPTED);
    op_end(1'b1, diskette_pkg::INT_CC_EXCEPTION, 16'h0004);
    dcb(16'h0040, 16'h0820, 16'h0101, 16'h0000, 16'h0000, 16'h0000);
    cmd(diskette_pkg::CMD_START, 16'h0040, diskette_pkg::CC_ACCEPTED);
    op_end(1'b1, diskette_pkg::INT_CC_EXCEPTION, 16'h0004);
    dcb(16'h0040, 16'h8020, 16'h0000, 16'h0080, 16'h0000, 16'h0000);
    dcb(16'h0080, 16'h0820, 16'h0100, 16'h0000, 16'h0000, 16'h0000);
    storage_model_inst.mem[8'h80] = 16'hffff;
    storage_model_inst.mem[8'h81] = 16'hffff;
    s0 = starts;
    cmd(diskette_pkg::CMD_START, 16'h0040, diskette_pkg::CC_ACCEPTED);
    op_end(1'b1, diskette_pkg::INT_CC_DEVICE_END, 16'h0000);
    chk("chained ops", 16'(starts - s0), 16'h0002);
    chk("status word 0", storage_model_inst.mem[8'h80], 16'h0000);
    chk("status flags", storage_model_inst.mem[8'h81], 16'h8001);
    cmd(diskette_pkg::CMD_PREPARE, 16'h000a, diskette_pkg::CC_ACCEPTED);
    dcb(16'h0040, 16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    cmd(diskette_pkg::CMD_START, 16'h0040, diskette_pkg::CC_ACCEPTED);
    op_end(1'b0, diskette_pkg::INT_CC_DEVICE_END, 16'h0000);
    cmd(diskette_pkg::CMD_PREPARE, 16'h000b, diskette_pkg::CC_ACCEPTED);
    delay <= 4'hf;
    dcb(16'h0040, 16'h0020, 16'h0000, 16'h0000, 16'h0004, 16'h00c0);
    cmd(diskette_pkg::CMD_START, 16'h0040, diskette_pkg::CC_ACCEPTED);
    cmd(diskette_pkg::CMD_DEV_RESET, 16'hffff, diskette_pkg::CC_ACCEPTED);
    chk("busy", {15'h0, busy}, 16'h0000);
    repeat (40) @(posedge sys_clk);
    #1;
    chk("reset kept", {11'h0, irq_req, irq_level}, 16'h0005);
    delay <= 4'h0;
    dcb(16'h0040, 16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    cmd(diskette_pkg::CMD_START, 16'h0040, diskette_pkg::CC_ACCEPTED);
    n = 0;
    while (irq_req !== 1'b1 && n < 500)
    begin
      @(posedge sys_clk);
      n = n + 1;
    end
    cmd(diskette_pkg::CMD_HALT, 16'hffff, diskette_pkg::CC_ACCEPTED);
    chk("halt kept", {10'h0, busy, irq_req, irq_level}, 16'h0005);
    finish_test;
  end
endmodule
